// File: logic/capture_cell.sv
// One capture-capable terminal: a sticky flag set by a rising edge while quick mode is on.
// Assumes the pin is synchronous to hclk and refresh and restart are one-cycle pulses.
`timescale 1ns/1ns
`include "qrl_map.svh"
module capture_cell
   import qrl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   input wire logic enable,
   input wire logic refresh,
   input wire logic restart,
   output logic sticky
);

   cell_state_t s;
   cell_state_t next_s;
   logic rise;

   always_comb begin
      next_s = s;
      rise = pin & ~s.prev;
      next_s.prev = pin;
      next_s.high_run = pin ? ((s.high_run == 10'h3ff) ? s.high_run : s.high_run + 10'h001)
                            : 10'h000;
      if (refresh || restart || !enable) begin
         next_s.sticky = 1'b0;
      end
      // A new edge in the refresh cycle survives, so no pulse is lost.
      if (enable && rise && !restart) begin
         next_s.sticky = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sticky = s.sticky;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   localparam int MinRun = `QRL_MIN_PULSE_CYC;

   edge_sets_a: assert property ((enable && rise && !restart) |=> sticky)
      else $error("rising edge did not set the sticky flag");
   set_has_cause_a: assert property ($rose(sticky) |-> $past(enable && pin && !s.prev))
      else $error("sticky flag set without a qualifying edge");
   long_pulse_a: assert property ((enable && !restart && !refresh && pin && !s.prev) ##1
      (enable && !restart && !refresh && pin) |-> sticky)
      else $error("pulse of two or more cycles was not captured");
   min_width_a: assert property ((s.high_run == 10'(MinRun) && enable)
      |-> (sticky || $past(refresh, 1) || $past(restart, 1) || !$past(enable, 1)))
      else $error("pulse of the minimum width was missed");

endmodule

// File: logic/quick_response_input_latch.sv
// Quick-response input latch for two pulse I/O modules, reached over AHB-Lite.
// Assumes inputs synchronous to hclk and software that requests each I/O refresh.
//
// Summary of operation
// - A quick-mode pulse of 30 us or more is always caught, whatever the scan.
// - Only terminals 0 to 3 of each module can capture; others stay plain inputs.
// - Module 0 reports in status word 2960 bits 0-3, module 1 in word 2962.
// - Each capture terminal latches only when its own setting selects quick mode.
// - New settings act only after a restart; until then the old ones hold.
// - A captured pulse stays in its status bit for one whole scan.
// - A presented captured pulse is cleared at the following I/O refresh.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ns
`include "qrl_map.svh"
module quick_response_input_latch
   import qrl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic mod0_capture_term_a,
   input wire logic mod0_capture_term_b,
   input wire logic mod0_capture_term_c,
   input wire logic mod0_capture_term_d,
   input wire logic [5:0] mod0_normal_inputs,
   input wire logic mod1_capture_term_a,
   input wire logic mod1_capture_term_b,
   input wire logic mod1_capture_term_c,
   input wire logic mod1_capture_term_d,
   input wire logic [5:0] mod1_normal_inputs
);

   latch_state_t s;
   latch_state_t next_s;
   quick_vec_t quick_pins;
   quick_vec_t sticky;
   quick_vec_t presented;
   logic addr_phase;
   logic data_write;
   logic do_refresh;
   logic do_restart;
   logic [31:0] read_word;

   // Terminals 4 to 9 never reach a capture cell, so they cannot latch.
   assign quick_pins.mod0 = {mod0_capture_term_d, mod0_capture_term_c,
                             mod0_capture_term_b, mod0_capture_term_a};
   assign quick_pins.mod1 = {mod1_capture_term_d, mod1_capture_term_c,
                             mod1_capture_term_b, mod1_capture_term_a};

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_cell
         capture_cell u_cell (
            .hclk(hclk),
            .hresetn(hresetn),
            .pin(quick_pins[gi]),
            .enable(s.cfg_active[gi]),
            .refresh(do_refresh),
            .restart(do_restart),
            .sticky(sticky[gi])
         );
      end
   endgenerate

   always_comb begin
      read_word = 32'h0000_0000;
      case (haddr[15:0])
         `QRL_STATUS0_ADDR: begin
            read_word[3:0] = s.status0;
         end
         `QRL_STATUS1_ADDR: begin
            read_word[3:0] = s.status1;
         end
         `QRL_CFG_PENDING_ADDR: begin
            read_word[7:0] = s.cfg_pending;
         end
         `QRL_CFG_ACTIVE_ADDR: begin
            read_word[7:0] = s.cfg_active;
         end
         `QRL_NORMAL_IN_ADDR: begin
            read_word[9:0] = s.normal0;
            read_word[`QRL_NORMAL1_LSB +: 10] = s.normal1;
         end
         `QRL_REFRESH_CNT_ADDR: begin
            read_word[15:0] = s.refresh_count;
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
      if (haddr[31:16] != 16'h0000) begin
         read_word = 32'h0000_0000;
      end
   end

   always_comb begin
      next_s = s;
      addr_phase = hsel && htrans[1] && hready;
      data_write = (s.phase == PHASE_WRITE);
      do_refresh = data_write && (s.wr_addr == `QRL_CONTROL_ADDR)
                   && hwdata[`QRL_CTRL_REFRESH_BIT];
      do_restart = data_write && (s.wr_addr == `QRL_CONTROL_ADDR)
                   && hwdata[`QRL_CTRL_RESTART_BIT];
      // The shown value is the sticky capture ORed with the present level.
      presented = s.cfg_active & (sticky | quick_pins);

      next_s.hreadyout = 1'b1;
      next_s.hresp = 1'b0;
      next_s.phase = PHASE_IDLE;
      if (addr_phase) begin
         if (hwrite && hsize == `QRL_HSIZE_WORD && haddr[31:16] == 16'h0000) begin
            next_s.phase = PHASE_WRITE;
            next_s.wr_addr = haddr[15:0];
         end else if (!hwrite) begin
            next_s.hrdata = read_word;
         end
      end

      if (data_write && s.wr_addr == `QRL_CFG_PENDING_ADDR) begin
         next_s.cfg_pending = hwdata[7:0];
      end

      case (s.phase)
         PHASE_WRITE: begin
            if (do_restart) begin
               // A restart stands for a power cycle: settings apply and all latches clear.
               next_s.cfg_active = s.cfg_pending;
               next_s.status0 = `QRL_STATUS_RESET;
               next_s.status1 = `QRL_STATUS_RESET;
               next_s.normal0 = 10'h000;
               next_s.normal1 = 10'h000;
            end else if (do_refresh) begin
               // Each refresh replaces the last picture, which drops a shown capture.
               next_s.status0 = presented.mod0;
               next_s.status1 = presented.mod1;
               next_s.normal0 = {mod0_normal_inputs, quick_pins.mod0 & ~s.cfg_active.mod0};
               next_s.normal1 = {mod1_normal_inputs, quick_pins.mod1 & ~s.cfg_active.mod1};
               next_s.refresh_count = s.refresh_count + 16'h0001;
            end
         end
         PHASE_IDLE: begin
            // Between refreshes the status words hold, so the scan sees a capture once.
            next_s.status0 = s.status0;
         end
         default: begin
            next_s.phase = PHASE_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s.phase <= PHASE_IDLE;
         s.wr_addr <= 16'h0000;
         s.hreadyout <= 1'b1;
         s.hresp <= 1'b0;
         s.hrdata <= 32'h0000_0000;
         s.cfg_pending <= `QRL_CFG_RESET;
         s.cfg_active <= `QRL_CFG_RESET;
         s.status0 <= `QRL_STATUS_RESET;
         s.status1 <= `QRL_STATUS_RESET;
         s.normal0 <= 10'h000;
         s.normal1 <= 10'h000;
         s.refresh_count <= 16'h0000;
      end else begin
         s <= next_s;
      end
   end

   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign hrdata = s.hrdata;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence refresh_seq;
      do_refresh && !do_restart;
   endsequence

   sequence restart_seq;
      do_restart;
   endsequence

   sequence write_addr_seq;
      addr_phase && hwrite && hsize == `QRL_HSIZE_WORD && haddr[31:16] == 16'h0000;
   endsequence

   sequence read_addr_seq;
      addr_phase && !hwrite;
   endsequence

   status_map_a: assert property (refresh_seq |=>
      (s.status0 == $past(s.cfg_active.mod0 & (sticky.mod0 | quick_pins.mod0))
       && s.status1 == $past(s.cfg_active.mod1 & (sticky.mod1 | quick_pins.mod1))))
      else $error("status words do not match terminals at refresh");

   normal_pins_a: assert property (refresh_seq |=>
      (s.normal0[9:4] == $past(mod0_normal_inputs)
       && s.normal1[9:4] == $past(mod1_normal_inputs)))
      else $error("plain inputs not passed through at refresh");

   quick_gate_a: assert property (((s.status0 & ~s.cfg_active.mod0) == 4'h0)
      && ((s.status1 & ~s.cfg_active.mod1) == 4'h0))
      else $error("status bit set on a terminal not in quick mode");

   cfg_apply_a: assert property (!$stable(s.cfg_active) |-> $past(do_restart))
      else $error("active settings changed without a restart");

   restart_load_a: assert property (restart_seq |=>
      (s.cfg_active == $past(s.cfg_pending) && s.status0 == 4'h0 && s.status1 == 4'h0))
      else $error("restart did not apply settings and clear status");

   status_hold_a: assert property ((!do_refresh && !do_restart) |=>
      ($stable(s.status0) && $stable(s.status1)))
      else $error("status changed between refreshes");

   capture_clear_a: assert property ((refresh_seq and (sticky == 8'h00 && quick_pins == 8'h00))
      |=> (s.status0 == 4'h0 && s.status1 == 4'h0))
      else $error("presented capture not cleared at next refresh");

   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("slave must be ready with an OKAY answer");

   read_data_a: assert property ((addr_phase && !hwrite
      && haddr == 32'(`QRL_CFG_ACTIVE_ADDR) && $stable(s.cfg_active))
      |=> hrdata == {24'h00_0000, $past(s.cfg_active)})
      else $error("read data of active settings wrong");

   write_phase_a: assert property (write_addr_seq |=>
      (s.phase == PHASE_WRITE && s.wr_addr == $past(haddr[15:0])))
      else $error("legal write address phase not captured");

   bad_size_a: assert property ((addr_phase && hwrite && hsize != `QRL_HSIZE_WORD)
      |=> s.phase == PHASE_IDLE)
      else $error("write of a size other than a word was taken");

   pending_write_a: assert property ((data_write && s.wr_addr == `QRL_CFG_PENDING_ADDR)
      |=> s.cfg_pending == $past(hwdata[7:0]))
      else $error("pending settings not written");

   pending_only_a: assert property (!$stable(s.cfg_pending)
      |-> $past(data_write && s.wr_addr == `QRL_CFG_PENDING_ADDR))
      else $error("pending settings changed without a write");

   refresh_count_a: assert property (refresh_seq |=>
      s.refresh_count == $past(s.refresh_count) + 16'h0001)
      else $error("refresh counter did not step");

   count_hold_a: assert property ((!do_refresh || do_restart) |=> $stable(s.refresh_count))
      else $error("refresh counter moved without a refresh");

   restart_plain_a: assert property (restart_seq |=>
      (s.normal0 == 10'h000 && s.normal1 == 10'h000))
      else $error("restart did not clear the plain picture");

   quick_plain_a: assert property (refresh_seq |=>
      ((s.normal0[3:0] & $past(s.cfg_active.mod0)) == 4'h0
       && (s.normal1[3:0] & $past(s.cfg_active.mod1)) == 4'h0))
      else $error("quick terminal shown in the plain picture");

   read_status0_a: assert property ((addr_phase && !hwrite && haddr == 32'(`QRL_STATUS0_ADDR))
      |=> hrdata == {28'h000_0000, $past(s.status0)})
      else $error("read data of status word 0 wrong");

   read_status1_a: assert property ((addr_phase && !hwrite && haddr == 32'(`QRL_STATUS1_ADDR))
      |=> hrdata == {28'h000_0000, $past(s.status1)})
      else $error("read data of status word 1 wrong");

   read_pending_a: assert property ((addr_phase && !hwrite
      && haddr == 32'(`QRL_CFG_PENDING_ADDR)) |=> hrdata == {24'h00_0000, $past(s.cfg_pending)})
      else $error("read data of pending settings wrong");

   read_count_a: assert property ((addr_phase && !hwrite
      && haddr == 32'(`QRL_REFRESH_CNT_ADDR)) |=> hrdata == {16'h0000, $past(s.refresh_count)})
      else $error("read data of refresh counter wrong");

   read_normal_a: assert property ((addr_phase && !hwrite && haddr == 32'(`QRL_NORMAL_IN_ADDR))
      |=> (hrdata[31:26] == 6'h00 && hrdata[15:10] == 6'h00))
      else $error("unused bits of the plain picture not zero");

   control_read_a: assert property ((addr_phase && !hwrite && haddr == 32'(`QRL_CONTROL_ADDR))
      |=> hrdata == 32'h0000_0000)
      else $error("control register did not read as zero");

   read_hold_a: assert property (!(addr_phase && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");

   unmapped_read_a: assert property ((read_addr_seq ##0 (haddr[31:16] != 16'h0000))
      |=> hrdata == 32'h0000_0000)
      else $error("unmapped read did not return zero");

endmodule

// File: shared/qrl_map.svh
// Register offsets, field positions, reset values and timing counts of the quick-response latch.
// Assumes byte addressing on a 32-bit AHB-Lite bus, one aligned word per register.
`ifndef QRL_MAP_SVH
`define QRL_MAP_SVH

// Printed word numbers are kept as register indices; byte address is four times the index.
`define QRL_STATUS0_IDX 12'hb90
`define QRL_STATUS1_IDX 12'hb92
`define QRL_STATUS0_ADDR {2'b00, `QRL_STATUS0_IDX, 2'b00}
`define QRL_STATUS1_ADDR {2'b00, `QRL_STATUS1_IDX, 2'b00}
`define QRL_CFG_PENDING_ADDR 16'h0000
`define QRL_CFG_ACTIVE_ADDR 16'h0004
`define QRL_CONTROL_ADDR 16'h0008
`define QRL_NORMAL_IN_ADDR 16'h000c
`define QRL_REFRESH_CNT_ADDR 16'h0010

// Control register fields.
`define QRL_CTRL_REFRESH_BIT 0
`define QRL_CTRL_RESTART_BIT 1
// Normal input register: module 1 levels start at this bit.
`define QRL_NORMAL1_LSB 16

// Reset values, and the HSIZE code of a word transfer.
`define QRL_CFG_RESET 8'h00
`define QRL_STATUS_RESET 4'h0
`define QRL_HSIZE_WORD 3'h2

// Shortest pulse that is always caught, and the clock period, in ns.
`define QRL_MIN_PULSE_NS 30000
`define QRL_CLK_NS 50
`define QRL_MIN_PULSE_CYC ((`QRL_MIN_PULSE_NS + `QRL_CLK_NS - 1) / `QRL_CLK_NS)

`endif

// File: shared/qrl_pkg.sv
// Types shared by the quick-response latch and its capture cells.
// Assumes the constants of qrl_map.svh are included where numbers are needed.
package qrl_pkg;

   typedef enum logic {PHASE_IDLE, PHASE_WRITE} bus_phase_t;

   typedef struct packed {
      logic [3:0] mod1;
      logic [3:0] mod0;
   } quick_vec_t;

   typedef struct packed {
      logic sticky;
      logic prev;
      logic [9:0] high_run;
   } cell_state_t;

   typedef struct packed {
      bus_phase_t phase;
      logic [15:0] wr_addr;
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
      quick_vec_t cfg_pending;
      quick_vec_t cfg_active;
      logic [3:0] status0;
      logic [3:0] status1;
      logic [9:0] normal0;
      logic [9:0] normal1;
      logic [15:0] refresh_count;
   } latch_state_t;

endpackage

// File: verif/pulse_sensor.sv
// Model of the external pulse sensors wired to the eight capture terminals.
// Assumes fire and width come from the bench just after a rising edge of hclk.
`timescale 1ns/1ns
module pulse_sensor (
   input wire logic hclk,
   input wire logic [7:0] fire,
   input wire logic [15:0] width,
   output logic [7:0] level
);
   logic [15:0] left;
   initial begin
      level = 8'h00;
      left = 16'h0000;
   end
   // An output that is off sits low, as the sensor draws no input current then.
   always @(posedge hclk) begin
      if (fire != 8'h00) begin
         level <= fire;
         left <= width - 16'h0001;
      end else if (left != 16'h0000) begin
         left <= left - 16'h0001;
      end else begin
         level <= 8'h00;
      end
   end
endmodule

// File: verif/testbench.sv
// Self-checking bench of the quick-response latch: AHB-Lite tasks and pulse scenarios.
// Assumes the pulse sensor model drives the capture terminals of both modules.
`timescale 1ns/1ns
`include "qrl_map.svh"
`define CHECK(what, exp, got) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("BAD %s expected %h seen %h", what, exp, got); \
      end \
   end
module testbench;
   localparam logic [31:0] do_refresh = 32'h0000_0001;
   localparam logic [31:0] do_restart = 32'h0000_0002;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [5:0] normal0;
   logic [5:0] normal1;
   logic [7:0] fire;
   logic [15:0] width;
   logic [7:0] level;
   int miscompares;
   int tests_run;
   quick_response_input_latch dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .mod0_capture_term_a(level[0]), .mod0_capture_term_b(level[1]),
      .mod0_capture_term_c(level[2]), .mod0_capture_term_d(level[3]),
      .mod0_normal_inputs(normal0),
      .mod1_capture_term_a(level[4]), .mod1_capture_term_b(level[5]),
      .mod1_capture_term_c(level[6]), .mod1_capture_term_d(level[7]),
      .mod1_normal_inputs(normal1)
   );
   pulse_sensor sensor (.hclk(hclk), .fire(fire), .width(width), .level(level));
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   task automatic finish_test();
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // The master holds each phase until hready is seen high, so wait states would be honoured.
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
         output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsize <= `QRL_HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      `CHECK("hresp", 1'b0, hresp)
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0000_0000, r);
      `CHECK(what, exp, r)
   endtask
   task automatic pulse(input logic [7:0] m, input logic [15:0] w);
      fire <= m;
      width <= w;
      @(posedge hclk);
      fire <= 8'h00;
      repeat (w + 3) @(posedge hclk);
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      miscompares++;
      finish_test();
   end
   initial begin
      miscompares = 0;
      tests_run = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = `QRL_HSIZE_WORD;
      hwdata = 32'h0000_0000;
      normal0 = 6'h2b;
      normal1 = 6'h15;
      fire = 8'h00;
      width = 16'h0001;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`QRL_STATUS0_ADDR, 32'h0000_0000, "status0 reset");
      rd(`QRL_STATUS1_ADDR, 32'h0000_0000, "status1 reset");
      rd(`QRL_CFG_ACTIVE_ADDR, 32'h0000_0000, "active reset");
      rd(32'h0000_0020, 32'h0000_0000, "unmapped");
      wr(`QRL_STATUS0_ADDR, 32'h0000_000f);
      rd(`QRL_STATUS0_ADDR, 32'h0000_0000, "status0 read only");
      wr(`QRL_CFG_PENDING_ADDR, 32'h0000_005a);
      rd(`QRL_CFG_PENDING_ADDR, 32'h0000_005a, "pending");
      rd(`QRL_CFG_ACTIVE_ADDR, 32'h0000_0000, "active before restart");
      // A pulse before the restart must still be ignored by every terminal.
      pulse(8'hff, 16'h0001);
      wr(`QRL_CONTROL_ADDR, do_refresh);
      rd(`QRL_STATUS0_ADDR, 32'h0000_0000, "status0 old setting");
      rd(`QRL_STATUS1_ADDR, 32'h0000_0000, "status1 old setting");
      rd(`QRL_REFRESH_CNT_ADDR, 32'h0000_0001, "refresh count");
      wr(`QRL_CONTROL_ADDR, do_restart);
      rd(`QRL_CFG_ACTIVE_ADDR, 32'h0000_005a, "active after restart");
      pulse(8'hff, 16'h0001);
      wr(`QRL_CONTROL_ADDR, do_refresh);
      rd(`QRL_STATUS0_ADDR, 32'h0000_000a, "status0 caught");
      rd(`QRL_STATUS1_ADDR, 32'h0000_0005, "status1 caught");
      rd(`QRL_STATUS0_ADDR, 32'h0000_000a, "status0 held");
      rd(`QRL_NORMAL_IN_ADDR, 32'h0150_02b0, "plain picture");
      wr(`QRL_CONTROL_ADDR, do_refresh);
      rd(`QRL_STATUS0_ADDR, 32'h0000_0000, "status0 cleared");
      rd(`QRL_STATUS1_ADDR, 32'h0000_0000, "status1 cleared");
      wr(`QRL_CFG_PENDING_ADDR, 32'h0000_00ff);
      wr(`QRL_CONTROL_ADDR, do_restart);
      // A pulse of exactly the shortest documented width, 600 cycles at 20 MHz.
      pulse(8'hff, 16'd600);
      wr(`QRL_CONTROL_ADDR, do_refresh);
      rd(`QRL_STATUS0_ADDR, 32'h0000_000f, "status0 min width");
      rd(`QRL_STATUS1_ADDR, 32'h0000_000f, "status1 min width");
      wr(`QRL_CONTROL_ADDR, do_refresh);
      rd(`QRL_STATUS1_ADDR, 32'h0000_0000, "status1 min cleared");
      // With both control bits set the restart wins, so a fresh capture is dropped.
      pulse(8'hff, 16'h0001);
      wr(`QRL_CONTROL_ADDR, do_refresh | do_restart);
      rd(`QRL_STATUS0_ADDR, 32'h0000_0000, "restart wins");
      rd(`QRL_REFRESH_CNT_ADDR, 32'h0000_0005, "refresh total");
      rd(`QRL_CFG_ACTIVE_ADDR, 32'h0000_00ff, "active kept");
      finish_test();
   end
endmodule
